/* File: inc/csl_cfg.svh */
// Offsets, field positions and reset values of the card socket register block
`ifndef CSL_CFG_SVH
`define CSL_CFG_SVH
// Function
// R01: Event pin driven only when routing field is 101b
// R02: Reserved event bits read zero, ignore writes
// R03: Socket 1 video change sets bit 10, W1C
// R04: Socket 0 video change sets bit 9, W1C
// R05: High voltage request change sets bit 8, W1C
// R06: Bit 2 enables socket 1 video event
// R07: Bit 1 enables socket 0 video event
// R08: Bit 0 enables high voltage request event
// R09: Sticky event bits survive bus reset
// R10: Index port at base, data at base plus one
// R11: One shared legacy I/O base register
// R12: Index 00h-3Fh socket A, 40h-7Fh socket B
// R13: Memory alias at 800h from each function base
// R14: Alias spans offsets 800h to 844h
// R15: Socket registers at offset 0h of window
// R16: Two byte-granular I/O windows per socket
// R17: Five 4K-granular memory windows per socket
// R18: Software programs 803h and 805h consistently
// R19: Event asserted while flag and enable both set
// R20: Window hit forwards host address plus offset
`define CSL_CFG_SOCK_BASE  8'h10
`define CSL_CFG_LEG_BASE   8'h44
`define CSL_CFG_ROUTE      8'h8C
`define CSL_CFG_EVENT      8'hA8
`define CSL_ROUTE_LSB      20
`define CSL_ROUTE_EVENT    3'h5
`define CSL_EVT_RESET      16'h0001
`define CSL_EVT_FLAG_LSB   8
`define CSL_LEG_ALIAS      12'h800
`define CSL_LEG_ALIAS_LAST 12'h844
`define CSL_LEG_BYTES      69
`define CSL_LEG_POWER      7'h02
`define CSL_LEG_WIN_EN     7'h06
`define CSL_LEG_IO_START   7'h08
`define CSL_LEG_IO_OFFSET  7'h36
`define CSL_LEG_MEM_START  7'h10
`define CSL_VPP_LSB        0
`define CSL_VPP12_CODE     2'h2
`define CSL_SOCK_REGS      4
`define CSL_IO_WINDOWS     2
`define CSL_MEM_WINDOWS    5
`endif

/* File: inc/csl_pkg.sv */
// Types shared by the card socket register block
`default_nettype none
package csl_pkg;
   typedef enum logic [1:0] {
      CSL_SPACE_CFG,
      CSL_SPACE_IO,
      CSL_SPACE_MEM,
      CSL_SPACE_NONE
   } csl_space_type;
   typedef struct packed {
      csl_space_type space;
      logic          func;
      logic          write;
      logic [31:0]   addr;
      logic [3:0]    be;
      logic [31:0]   wdata;
   } csl_req_type;
   typedef struct packed {
      logic        claim;
      logic [31:0] rdata;
   } csl_rsp_type;
   typedef struct packed {
      logic        io;
      logic        sock;
      logic        write;
      logic [25:0] addr;
   } csl_fwd_type;
endpackage
`default_nettype wire

/* File: rtl/csl_window.sv */
// Address window compare and translation for one host window
`default_nettype none
module csl_window (
   input  wire logic [31:0] start_addr,
   input  wire logic [31:0] end_addr,
   input  wire logic [31:0] offset_addr,
   input  wire logic        enable,
   input  wire logic [31:0] addr,
   output logic             hit,
   output logic [31:0]      card_addr
);
   // Inclusive bounds; granularity is set by how the caller scales them
   assign hit       = enable && (addr >= start_addr) && (addr <= end_addr); // R16 R17
   assign card_addr = addr + offset_addr; // R20
endmodule
`default_nettype wire

/* File: rtl/csl_event_reg.sv */
// General event control and status register
`include "csl_cfg.svh"
`default_nettype none
module csl_event_reg (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wr,
   input  wire logic [1:0]  be,
   input  wire logic [15:0] wdata,
   input  wire logic [1:0]  video_port_enable,
   input  wire logic        vpp12_change,
   output logic [15:0]      value,
   output logic             event_level
);
   logic [1:0] video_prev;
   logic       armed;
   logic [1:0] video_change;
   logic [2:0] flag_set;
   logic [2:0] flag_clear;

   // No change is reported on the first edge after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed      <= 1'b0;
         video_prev <= 2'h0;
      end else begin
         armed      <= 1'b1;
         video_prev <= video_port_enable;
      end
   end

   assign video_change = armed ? (video_prev ^ video_port_enable) : 2'h0;
   assign flag_set     = {video_change, vpp12_change};
   assign flag_clear   = (wr && be[1]) ? wdata[10:8] : 3'h0;

   // Only the global reset reaches this register
   always_ff @(posedge clk or negedge rst_n) begin // R09
      if (!rst_n) begin
         value <= `CSL_EVT_RESET;
      end else begin
         // Set wins over a simultaneous write-one clear
         value[10:8] <= (value[10:8] & ~flag_clear) | flag_set; // R03 R04 R05
         if (wr && be[0]) begin
            value[2:0] <= wdata[2:0];
         end
         value[15:11] <= 5'h00; // R02
         value[7:3]   <= 5'h00; // R02
      end
   end

   assign event_level = |(value[10:8] & value[2:0]); // R06 R07 R08 R19

   v1_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R03
      video_change[1] |=> value[10]) else $error("socket 1 video flag not set");
   v0_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R04
      video_change[0] |=> value[9]) else $error("socket 0 video flag not set");
   vpp_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R05
      (wr && be[1] && wdata[8] && !vpp12_change) |=> !value[8])
      else $error("voltage flag not cleared");
   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R02
      value[15:11] == 5'h00 && value[7:3] == 5'h00) else $error("reserved bits set");
   enable_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R06
      !(wr && be[0]) |=> $stable(value[2:0])) else $error("enable bits changed");
   flag_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      video_change[1] ##1 value[10] && value[2]);
endmodule
`default_nettype wire

/* File: rtl/csl_top.sv */
// Socket event register, legacy register file, alias decode and host windows
`include "csl_cfg.svh"
`default_nettype none
module csl_top (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 bus_reset_n,
   input  wire logic                 req_valid,
   input  wire csl_pkg::csl_req_type req,
   input  wire logic [1:0]           video_port_enable,
   output logic                      rsp_valid,
   output csl_pkg::csl_rsp_type      rsp,
   output logic                      fwd_valid,
   output csl_pkg::csl_fwd_type      fwd,
   output logic                      multifunction_pin_five,
   output logic                      multifunction_pin_five_oe
);
   import csl_pkg::*;

   logic [31:0] route_reg;
   logic [31:0] sock_base [2];
   logic [15:0] leg_base;
   logic [7:0]  leg_index;
   logic [7:0]  leg_regs  [2][`CSL_LEG_BYTES];
   logic [31:0] sock_regs [2][`CSL_SOCK_REGS];
   logic [15:0] evt_value;
   logic        evt_level;
   logic        routed;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [7:0] lane_byte(input logic [31:0] data,
                                            input logic [1:0]  lane);
      return data[8*lane +: 8];
   endfunction

   function automatic logic is_vpp12(input logic [7:0] power);
      return power[`CSL_VPP_LSB +: 2] == `CSL_VPP12_CODE;
   endfunction

   // Host decode
   logic       wr_req;
   logic       cfg_acc;
   logic [7:0] cfg_off;
   logic       io_sel;
   logic       io_idx;
   logic       io_dat;
   logic       mem_f0;
   logic       mem_f1;
   logic       mem_hit;
   logic       mem_func;
   logic [11:0] mem_ofs;
   logic       alias_ok;
   logic       sreg_hit;
   logic       own_claim;

   assign wr_req  = req_valid && req.write;
   assign cfg_acc = req.space == CSL_SPACE_CFG;
   assign cfg_off = {req.addr[7:2], 2'h0};

   // Index at the shared base, data at base plus one
   assign io_sel = (req.space == CSL_SPACE_IO) && (req.addr[31:16] == 16'h0000)
                   && (leg_base != 16'h0000)
                   && (req.addr[15:1] == leg_base[15:1]); // R10 R11
   assign io_idx = io_sel && !req.addr[0]; // R10
   assign io_dat = io_sel && req.addr[0]; // R10

   // Each function owns a 4K window; function 0 wins if both overlap
   assign mem_f0 = (req.space == CSL_SPACE_MEM) && (sock_base[0] != 32'h0)
                   && (req.addr[31:12] == sock_base[0][31:12]); // R13
   assign mem_f1 = (req.space == CSL_SPACE_MEM) && (sock_base[1] != 32'h0)
                   && (req.addr[31:12] == sock_base[1][31:12]); // R13
   assign mem_hit  = mem_f0 || mem_f1;
   assign mem_func = !mem_f0;
   assign mem_ofs  = req.addr[11:0];
   assign alias_ok = (mem_ofs >= `CSL_LEG_ALIAS) && (mem_ofs <= `CSL_LEG_ALIAS_LAST); // R14
   assign sreg_hit = mem_ofs[11:4] == 8'h00; // R15
   assign own_claim = cfg_acc || io_sel || mem_hit;

   // Legacy register target, from the index pair or the memory alias
   logic       leg_acc;
   logic       leg_sock;
   logic [6:0] leg_off;
   logic       leg_ok;
   logic       leg_we;
   logic [7:0] leg_wbyte;
   logic [7:0] leg_rbyte;
   logic       vpp12_change;
   logic [11:0] alias_ofs;

   assign alias_ofs = mem_ofs - `CSL_LEG_ALIAS;

   always_comb begin
      leg_acc  = 1'b0;
      leg_sock = 1'b0;
      leg_off  = 7'h00;
      leg_ok   = 1'b0;
      if (io_dat) begin
         leg_acc  = 1'b1;
         leg_sock = leg_index[6]; // R12
         leg_off  = {1'b0, leg_index[5:0]}; // R12
         leg_ok   = !leg_index[7];
      end else if (mem_hit && alias_ok) begin
         leg_acc  = 1'b1;
         leg_sock = mem_func; // R13
         leg_off  = alias_ofs[6:0]; // R14
         leg_ok   = 1'b1;
      end
   end

   assign leg_we    = wr_req && leg_acc && leg_ok;
   assign leg_wbyte = lane_byte(req.wdata, req.addr[1:0]);
   assign leg_rbyte = leg_regs[leg_sock][leg_off];
   // A software move onto or off the high programming voltage
   assign vpp12_change = leg_we && (leg_off == `CSL_LEG_POWER)
                         && (is_vpp12(leg_rbyte) != is_vpp12(leg_wbyte)); // R05 R08

   // Configuration registers follow both resets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         route_reg    <= 32'h0;
         sock_base[0] <= 32'h0;
         sock_base[1] <= 32'h0;
         leg_base     <= 16'h0000;
      end else if (!bus_reset_n) begin
         route_reg    <= 32'h0;
         sock_base[0] <= 32'h0;
         sock_base[1] <= 32'h0;
         leg_base     <= 16'h0000;
      end else if (wr_req && cfg_acc) begin
         case (cfg_off)
            `CSL_CFG_ROUTE: begin
               route_reg <= merge(route_reg, req.wdata, req.be);
            end
            `CSL_CFG_SOCK_BASE: begin
               // Low twelve bits fixed: the window is 4K aligned
               sock_base[req.func] <= merge(sock_base[req.func], req.wdata, req.be)
                                      & 32'hFFFFF000;
            end
            `CSL_CFG_LEG_BASE: begin
               leg_base <= 16'(merge({16'h0000, leg_base}, req.wdata, req.be)
                               & 32'h0000FFFE); // R11
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         leg_index <= 8'h00;
      end else if (!bus_reset_n) begin
         leg_index <= 8'h00;
      end else if (wr_req && io_idx) begin
         leg_index <= lane_byte(req.wdata, req.addr[1:0]); // R10
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < `CSL_LEG_BYTES; i++) begin
               leg_regs[s][i] <= 8'h00;
            end
         end
      end else if (!bus_reset_n) begin
         for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < `CSL_LEG_BYTES; i++) begin
               leg_regs[s][i] <= 8'h00;
            end
         end
      end else if (leg_we) begin
         leg_regs[leg_sock][leg_off] <= leg_wbyte; // R10 R13
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < `CSL_SOCK_REGS; i++) begin
               sock_regs[s][i] <= 32'h0;
            end
         end
      end else if (!bus_reset_n) begin
         for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < `CSL_SOCK_REGS; i++) begin
               sock_regs[s][i] <= 32'h0;
            end
         end
      end else if (wr_req && mem_hit && sreg_hit) begin
         sock_regs[mem_func][mem_ofs[3:2]] <=
            merge(sock_regs[mem_func][mem_ofs[3:2]], req.wdata, req.be); // R15
      end
   end

   // Event register sits outside the bus reset
   csl_event_reg u_event (
      .clk               (clk),
      .rst_n             (rst_n),
      .wr                (wr_req && cfg_acc && (cfg_off == `CSL_CFG_EVENT)),
      .be                (req.be[1:0]),
      .wdata             (req.wdata[15:0]),
      .video_port_enable (video_port_enable),
      .vpp12_change      (vpp12_change),
      .value             (evt_value),
      .event_level       (evt_level)
   );

   // Host windows, two I/O and five memory per socket
   logic [`CSL_IO_WINDOWS-1:0]  io_hit   [2];
   logic [31:0]                 io_card  [2][`CSL_IO_WINDOWS];
   logic [`CSL_MEM_WINDOWS-1:0] mem_whit [2];
   logic [31:0]                 mem_card [2][`CSL_MEM_WINDOWS];

   for (genvar s = 0; s < 2; s++) begin : g_sock
      for (genvar w = 0; w < `CSL_IO_WINDOWS; w++) begin : g_io
         localparam logic [6:0] START = 7'(`CSL_LEG_IO_START + 4 * w);
         localparam logic [6:0] OFS   = 7'(`CSL_LEG_IO_OFFSET + 2 * w);
         csl_window u_win (
            // Bytes are named directly so the bounds follow every register write
            .start_addr  ({16'h0000, leg_regs[s][START + 7'h01], leg_regs[s][START]}),
            .end_addr    ({16'h0000, leg_regs[s][START + 7'h03], leg_regs[s][START + 7'h02]}),
            .offset_addr ({16'h0000, leg_regs[s][OFS + 7'h01], leg_regs[s][OFS]}),
            .enable      (leg_regs[s][`CSL_LEG_WIN_EN][6 + w]),
            .addr        (req.addr),
            .hit         (io_hit[s][w]),
            .card_addr   (io_card[s][w])
         ); // R16
      end
      for (genvar w = 0; w < `CSL_MEM_WINDOWS; w++) begin : g_mem
         localparam logic [6:0] START = 7'(`CSL_LEG_MEM_START + 8 * w);
         // Page numbers: start and end cover whole 4K pages
         csl_window u_win (
            .start_addr  ({8'h00, leg_regs[s][START + 7'h01][3:0], leg_regs[s][START],
                           12'h000}),
            .end_addr    ({8'h00, leg_regs[s][START + 7'h03][3:0], leg_regs[s][START + 7'h02],
                           12'hFFF}),
            .offset_addr ({6'h00, leg_regs[s][START + 7'h05][5:0], leg_regs[s][START + 7'h04],
                           12'h000}),
            .enable      (leg_regs[s][`CSL_LEG_WIN_EN][w]),
            .addr        (req.addr),
            .hit         (mem_whit[s][w]),
            .card_addr   (mem_card[s][w])
         ); // R17
      end
   end

   // Lowest socket, then lowest window, takes an overlapping access
   logic        next_fwd_valid;
   csl_fwd_type next_fwd;

   always_comb begin
      next_fwd_valid = 1'b0;
      next_fwd       = '0;
      for (int s = 0; s < 2; s++) begin
         for (int w = 0; w < `CSL_IO_WINDOWS; w++) begin
            if (!next_fwd_valid && io_hit[s][w] && req.space == CSL_SPACE_IO) begin
               next_fwd_valid = 1'b1;
               next_fwd       = '{io: 1'b1, sock: 1'(s), write: req.write,
                                  addr: io_card[s][w][25:0]}; // R20
            end
         end
         for (int w = 0; w < `CSL_MEM_WINDOWS; w++) begin
            if (!next_fwd_valid && mem_whit[s][w] && req.space == CSL_SPACE_MEM) begin
               next_fwd_valid = 1'b1;
               next_fwd       = '{io: 1'b0, sock: 1'(s), write: req.write,
                                  addr: mem_card[s][w][25:0]}; // R20
            end
         end
      end
      if (!req_valid || own_claim) begin
         next_fwd_valid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fwd_valid <= 1'b0;
         fwd       <= '0;
      end else begin
         fwd_valid <= next_fwd_valid;
         fwd       <= next_fwd;
      end
   end

   // Read data
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0;
      if (cfg_acc) begin
         case (cfg_off)
            `CSL_CFG_ROUTE:     next_rdata = route_reg;
            `CSL_CFG_SOCK_BASE: next_rdata = sock_base[req.func];
            `CSL_CFG_LEG_BASE:  next_rdata = {16'h0000, leg_base};
            `CSL_CFG_EVENT:     next_rdata = {16'h0000, evt_value}; // R02
            default:            next_rdata = 32'h0;
         endcase
      end else if (io_idx) begin
         next_rdata = {4{leg_index}};
      end else if (leg_acc) begin
         // Byte replicated on all lanes; unmapped index reads zero
         next_rdata = leg_ok ? {4{leg_rbyte}} : 32'h0;
      end else if (mem_hit && sreg_hit) begin
         next_rdata = sock_regs[mem_func][mem_ofs[3:2]]; // R15
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp       <= '0;
      end else begin
         rsp_valid <= req_valid;
         rsp       <= '{claim: req_valid && own_claim, rdata: next_rdata};
      end
   end

   // Event pin
   assign routed = route_reg[`CSL_ROUTE_LSB +: 3] == `CSL_ROUTE_EVENT; // R01

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         multifunction_pin_five    <= 1'b0;
         multifunction_pin_five_oe <= 1'b0;
      end else begin
         multifunction_pin_five    <= routed && evt_level; // R01 R19
         multifunction_pin_five_oe <= routed; // R01
      end
   end

   route_pin_a: assert property (@(posedge clk) disable iff (!rst_n) // R01
      multifunction_pin_five_oe == $past(route_reg[22:20] == 3'h5))
      else $error("pin enable does not follow routing");
   pin_event_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
      (routed && |(evt_value[10:8] & evt_value[2:0])) |=> multifunction_pin_five)
      else $error("event pin not asserted");
   sticky_bus_a: assert property (@(posedge clk) disable iff (!rst_n) // R09
      (!bus_reset_n && !wr_req) |=> $stable(evt_value[2:0]))
      else $error("enables lost on bus reset");
   io_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
      (req_valid && !req.write && io_dat && !leg_index[7])
      |=> rsp.rdata[7:0] == $past(leg_rbyte)) else $error("data port read wrong");
   index_sock_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
      (io_dat && leg_index >= 8'h40 && leg_index <= 8'h7F) |-> leg_sock && leg_ok)
      else $error("upper index not socket B");
   mem_claim_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
      (req_valid && req.space == CSL_SPACE_MEM && sock_base[1] != 32'h0
       && req.addr[31:12] == sock_base[1][31:12]) |=> rsp_valid && rsp.claim)
      else $error("memory alias not claimed");
   fwd_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // R20
      (req_valid && !own_claim && req.space == CSL_SPACE_IO && io_hit[0][0])
      |=> fwd_valid && fwd.addr == $past(io_card[0][0][25:0]))
      else $error("forward address wrong");
   pin_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      multifunction_pin_five_oe && multifunction_pin_five);
   io_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      req_valid && io_idx ##1 req_valid && io_dat);
   fwd_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      fwd_valid && !fwd.io);
endmodule
`default_nettype wire

/* File: verification/csl_host_model.sv */
// Host bus master model issuing config, I/O and memory requests
`default_nettype none
module csl_host_model (
   input  wire logic                 clk,
   output logic                      req_valid,
   output csl_pkg::csl_req_type      req,
   input  wire logic                 rsp_valid,
   input  wire csl_pkg::csl_rsp_type rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   import csl_pkg::*;
   csl_rsp_type last;
   logic        vld;
   initial begin
      req_valid = 1'b0;
      req       = '0;
   end
   // One request pulse; the answer is registered one cycle later
   task automatic xfer(input csl_space_type sp, input logic fn, input logic wr,
                       input logic [31:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge clk);
      req_valid <= 1'b1;
      req       <= '{sp, fn, wr, a, b, d};
      @(posedge clk);
      req_valid <= 1'b0;
      // A released bus must not keep looking like the last request
      req       <= ~req;
      #1;
      vld  = rsp_valid;
      last = rsp;
   endtask
   task automatic leg(input logic [31:0] base, input logic [7:0] idx,
                      input logic wr, input logic [7:0] d);
      xfer(CSL_SPACE_IO, 1'b0, 1'b1, base, 4'h1, {4{idx}});
      xfer(CSL_SPACE_IO, 1'b0, wr, base + 32'h1, 4'h2, {4{d}});
   endtask
   // Interrupt control and status-change routing left in polled mode
   task automatic irq_setup(input logic [31:0] win);
      xfer(CSL_SPACE_MEM, 1'b0, 1'b1, win + 32'h803, 4'h8, 32'h0);
      xfer(CSL_SPACE_MEM, 1'b0, 1'b1, win + 32'h805, 4'h2, 32'h0);
   endtask
endmodule
`default_nettype wire

/* File: verification/csl_bench.sv */
// Self-checking bench for the socket event register and legacy access
`default_nettype none
`define CHK(g, e) \
   begin \
      checks_done++; \
      if ((g) !== (e)) begin \
         n_fail++; \
         $display("[FAIL] %0t: got %0h expected %0h", $time, (g), (e)); \
      end \
   end
module card_socket_event_and_legacy_access_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import csl_pkg::*;
   localparam logic [31:0] IOB = 32'h0000_03E0;
   localparam logic [31:0] WIN = 32'h8000_0000;
   logic        clk;
   logic        rst_n;
   logic        bus_reset_n;
   logic        req_valid;
   logic        rsp_valid;
   logic        fwd_valid;
   logic        pin;
   logic        pin_oe;
   logic [1:0]  vpe;
   csl_req_type req;
   csl_rsp_type rsp;
   csl_fwd_type fwd;
   int          n_fail = 0;
   int          checks_done = 0;
   csl_top dut (.clk(clk), .rst_n(rst_n), .bus_reset_n(bus_reset_n), .req_valid(req_valid),
      .req(req), .video_port_enable(vpe), .rsp_valid(rsp_valid), .rsp(rsp),
      .fwd_valid(fwd_valid), .fwd(fwd), .multifunction_pin_five(pin),
      .multifunction_pin_five_oe(pin_oe));
   csl_host_model host (.clk(clk), .req_valid(req_valid), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cfg_wr(input logic fn, input logic [7:0] a, input logic [31:0] d);
      host.xfer(CSL_SPACE_CFG, fn, 1'b1, {24'h0, a}, 4'hF, d);
   endtask
   task automatic chk_evt(input logic [15:0] e);
      host.xfer(CSL_SPACE_CFG, 1'b0, 1'b0, 32'hA8, 4'h3, 32'h0);
      `CHK(host.last.rdata[15:0], e)
   endtask
   task automatic toggle(input int b);
      @(posedge clk);
      vpe[b] <= ~vpe[b];
      settle(4);
   endtask
   task automatic t_reset_value();
      chk_evt(16'h0001);
      cfg_wr(1'b0, 8'hA8, 32'h0000_FFFF);
      chk_evt(16'h0007);
      `CHK(host.vld, 1'b1);
      $display("reset value and reserved bits done");
   endtask
   task automatic t_video();
      cfg_wr(1'b0, 8'h8C, 32'h0050_0000);
      settle(2);
      `CHK(pin_oe, 1'b1);
      toggle(0);
      `CHK(pin, 1'b1);
      chk_evt(16'h0207);
      cfg_wr(1'b0, 8'hA8, 32'h0000_0207);
      chk_evt(16'h0007);
      settle(2);
      `CHK(pin, 1'b0);
      toggle(1);
      `CHK(pin, 1'b1);
      chk_evt(16'h0407);
      cfg_wr(1'b0, 8'hA8, 32'h0000_0400);
      toggle(0);
      `CHK(pin, 1'b0);
      chk_evt(16'h0200);
      cfg_wr(1'b0, 8'hA8, 32'h0000_0201);
      $display("video change events done");
   endtask
   task automatic t_legacy();
      cfg_wr(1'b0, 8'h44, IOB);
      host.leg(IOB, 8'h02, 1'b1, 8'h02);
      settle(2);
      `CHK(pin, 1'b1);
      chk_evt(16'h0101);
      host.leg(IOB, 8'h45, 1'b1, 8'hAA);
      host.leg(IOB, 8'h45, 1'b0, 8'h00);
      `CHK(host.last.rdata, {4{8'hAA}});
      host.leg(IOB, 8'h05, 1'b0, 8'h00);
      `CHK(host.last.rdata, 32'h0);
      host.leg(IOB, 8'hC5, 1'b1, 8'h55);
      host.leg(IOB, 8'hC5, 1'b0, 8'h00);
      `CHK(host.last.rdata, 32'h0);
      host.leg(IOB, 8'h45, 1'b0, 8'h00);
      `CHK(host.last.rdata, {4{8'hAA}});
      cfg_wr(1'b1, 8'h10, WIN);
      host.xfer(CSL_SPACE_MEM, 1'b0, 1'b0, WIN + 32'h805, 4'h2, 32'h0);
      `CHK(host.last.rdata, {4{8'hAA}});
      host.xfer(CSL_SPACE_MEM, 1'b0, 1'b0, WIN + 32'h845, 4'h2, 32'h0);
      `CHK(host.last, {1'b1, 32'h0});
      host.xfer(CSL_SPACE_MEM, 1'b0, 1'b1, WIN, 4'hF, 32'h1234_5678);
      host.xfer(CSL_SPACE_MEM, 1'b0, 1'b0, WIN, 4'hF, 32'h0);
      `CHK(host.last.rdata, 32'h1234_5678);
      host.irq_setup(WIN);
      $display("legacy access done");
   endtask
   // Socket A I/O window 0 at 300h-30Fh plus 100h, memory window 0 on pages 123h-124h plus 10h
   task automatic t_windows();
      host.leg(IOB, 8'h08, 1'b1, 8'h00);
      host.leg(IOB, 8'h09, 1'b1, 8'h03);
      host.leg(IOB, 8'h0A, 1'b1, 8'h0F);
      host.leg(IOB, 8'h0B, 1'b1, 8'h03);
      host.leg(IOB, 8'h36, 1'b1, 8'h00);
      host.leg(IOB, 8'h37, 1'b1, 8'h01);
      host.leg(IOB, 8'h10, 1'b1, 8'h23);
      host.leg(IOB, 8'h11, 1'b1, 8'h01);
      host.leg(IOB, 8'h12, 1'b1, 8'h24);
      host.leg(IOB, 8'h13, 1'b1, 8'h01);
      host.leg(IOB, 8'h14, 1'b1, 8'h10);
      host.leg(IOB, 8'h15, 1'b1, 8'h00);
      host.leg(IOB, 8'h06, 1'b1, 8'h41);
      host.xfer(CSL_SPACE_IO, 1'b0, 1'b0, 32'h0000_0305, 4'h1, 32'h0);
      `CHK(host.last.claim, 1'b0)
      `CHK(fwd_valid, 1'b1)
      `CHK(fwd, {1'b1, 1'b0, 1'b0, 26'h000_0405})
      host.xfer(CSL_SPACE_IO, 1'b0, 1'b1, 32'h0000_0310, 4'h1, 32'h0);
      `CHK(fwd_valid, 1'b0)
      host.xfer(CSL_SPACE_MEM, 1'b0, 1'b1, 32'h0012_4ABC, 4'hF, 32'h0);
      `CHK(fwd_valid, 1'b1)
      `CHK(fwd, {1'b0, 1'b0, 1'b1, 26'h013_4ABC})
      host.xfer(CSL_SPACE_MEM, 1'b0, 1'b0, 32'h0012_2FFF, 4'hF, 32'h0);
      `CHK(fwd_valid, 1'b0)
      $display("host windows done");
   endtask
   task automatic t_bus_reset();
      @(posedge clk);
      bus_reset_n <= 1'b0;
      @(posedge clk);
      bus_reset_n <= 1'b1;
      settle(2);
      `CHK(pin_oe, 1'b0);
      chk_evt(16'h0101);
      host.xfer(CSL_SPACE_IO, 1'b0, 1'b0, IOB + 32'h1, 4'h2, 32'h0);
      `CHK(host.last.claim, 1'b0);
      $display("bus reset done");
   endtask
   initial begin
      rst_n = 1'b0;
      bus_reset_n = 1'b1;
      vpe = 2'b00;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      settle(2);
      t_reset_value();
      t_video();
      t_legacy();
      t_windows();
      t_bus_reset();
      finish_test();
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      #50000;
      n_fail++;
      finish_test();
   end
endmodule
`default_nettype wire
